// [design/irc_top.sv]
// Bucket 0 global ingress rate configuration with per-port enables.
// Assumes an Avalon-MM slave, a strap pin and per-port traffic class inputs.
`timescale 1ns/10ps
module irc_top #(
  parameter int PORTS = 7
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [7:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  input  wire logic [3:0]       avs_byteenable,
  output logic [31:0]           avs_readdata,
  output logic                  avs_waitrequest,
  input  wire logic             storm_limit_strap,
  input  wire logic [6:0]       frame_class_in [PORTS],
  output logic [PORTS-1:0]      bucket0_police,
  output logic                  bucket0_rate_mode_select,
  output logic [6:0]            bucket0_traffic_class_mask
);
  logic             strap_meta_reg;
  logic             strap_sync_reg;
  logic             init_reg;
  logic             ack_reg;
  logic             rsvd7_reg;
  logic [PORTS-1:0] port_en_reg;
  logic             wr_go;
  logic             rd_go;

  // Strap synchroniser
  always_ff @(posedge clk) begin
    strap_meta_reg <= storm_limit_strap;
    strap_sync_reg <= strap_meta_reg;
  end

  // Strap capture armed by reset, loads at the first clock edge after reset is released
  always_ff @(posedge clk) begin
    if (!reset_n) init_reg <= 1'b1;
    else          init_reg <= 1'b0;
  end

  // Writes commit only at the edge where waitrequest is seen low
  assign wr_go = avs_write && ack_reg;
  assign rd_go = avs_read && !ack_reg && !init_reg;

  // One wait cycle per access
  always_ff @(posedge clk) begin
    if (!reset_n) ack_reg <= 1'b0;
    else          ack_reg <= (avs_read || avs_write) && !ack_reg && !init_reg;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) avs_waitrequest <= 1'b1;
    else          avs_waitrequest <= !((avs_read || avs_write) && !ack_reg && !init_reg);
  end

  // Mode select and reserved bit
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bucket0_rate_mode_select <= 1'b0;
      rsvd7_reg                <= irc_pkg::RSVD_RESET;
    end else if (init_reg) begin
      bucket0_rate_mode_select <= strap_sync_reg; // see RULE3
    end else if (wr_go && avs_address == irc_pkg::GLOBAL_CFG_ADDR && avs_byteenable[1]) begin
      bucket0_rate_mode_select <= avs_writedata[irc_pkg::MODE_BIT]; // see RULE1 see RULE2
    end else if (wr_go && avs_address == irc_pkg::GLOBAL_CFG_ADDR && avs_byteenable[0]) begin
      rsvd7_reg <= avs_writedata[irc_pkg::RSVD_BIT]; // see RULE8
    end
  end

  // Traffic class mask
  always_ff @(posedge clk) begin
    if (!reset_n) bucket0_traffic_class_mask <= irc_pkg::MASK_STRAP_LOW;
    else if (init_reg)
      bucket0_traffic_class_mask <= strap_sync_reg ? irc_pkg::MASK_STRAP_HIGH
                                                   : irc_pkg::MASK_STRAP_LOW; // see RULE6
    else if (wr_go && avs_address == irc_pkg::GLOBAL_CFG_ADDR && avs_byteenable[0])
      bucket0_traffic_class_mask <= avs_writedata[irc_pkg::MASK_MSB:0]; // see RULE4
  end

  // Per-port bucket 0 enables
  always_ff @(posedge clk) begin
    if (!reset_n) port_en_reg <= '0;
    else if (init_reg) port_en_reg <= {PORTS{strap_sync_reg}}; // see RULE7
    else if (wr_go && avs_address == irc_pkg::PORT_EN_ADDR && avs_byteenable[0])
      port_en_reg <= avs_writedata[PORTS-1:0];
  end

  // Per-port policing select: class in mask and port enabled
  generate
    for (genvar p = 0; p < PORTS; p++) begin : g_port
      always_ff @(posedge clk) begin
        if (!reset_n) bucket0_police[p] <= 1'b0;
        else bucket0_police[p] <= port_en_reg[p] &&
                                  |(frame_class_in[p] & bucket0_traffic_class_mask); // see RULE5
      end
    end
  endgenerate

  // Read data
  always_ff @(posedge clk) begin
    if (!reset_n) avs_readdata <= irc_pkg::UNMAPPED_READ;
    else if (rd_go) begin
      unique case (avs_address)
        irc_pkg::GLOBAL_CFG_ADDR: avs_readdata <= {23'h000000, bucket0_rate_mode_select,
                                                   rsvd7_reg, bucket0_traffic_class_mask};
        irc_pkg::PORT_EN_ADDR:    avs_readdata <= 32'(port_en_reg);
        irc_pkg::STATUS_ADDR:     avs_readdata <= 32'(bucket0_police);
        default:                  avs_readdata <= irc_pkg::UNMAPPED_READ;
      endcase
    end
  end

  // Strap load: mask follows the synchronised strap
  strap_mask_a: assert property (@(posedge clk) disable iff (!reset_n) // see RULE6
    init_reg |=> bucket0_traffic_class_mask ==
                 ($past(strap_sync_reg) ? irc_pkg::MASK_STRAP_HIGH : irc_pkg::MASK_STRAP_LOW))
    else $error("mask reset value wrong");

  // Strap load: mode bit follows the synchronised strap
  strap_mode_a: assert property (@(posedge clk) disable iff (!reset_n) // see RULE3
    init_reg |=> bucket0_rate_mode_select == $past(strap_sync_reg))
    else $error("mode reset value wrong");

  // Strap load: every port enable follows the synchronised strap
  strap_en_a: assert property (@(posedge clk) disable iff (!reset_n) // see RULE7
    init_reg |=> port_en_reg == {PORTS{$past(strap_sync_reg)}})
    else $error("enable reset value wrong");

  // Mode bit takes the written value
  mode_write_a: assert property (@(posedge clk) disable iff (!reset_n) // see RULE3
    wr_go && avs_address == irc_pkg::GLOBAL_CFG_ADDR && avs_byteenable[1]
    |=> bucket0_rate_mode_select == $past(avs_writedata[irc_pkg::MODE_BIT]))
    else $error("mode write lost");

  // Writing zero selects absolute rate
  mode_abs_a: assert property (@(posedge clk) disable iff (!reset_n) // see RULE1
    wr_go && avs_address == irc_pkg::GLOBAL_CFG_ADDR && avs_byteenable[1]
    && !avs_writedata[irc_pkg::MODE_BIT] |=> !bucket0_rate_mode_select)
    else $error("absolute mode not selected");

  // Writing one selects link-speed normalized rate
  mode_norm_a: assert property (@(posedge clk) disable iff (!reset_n) // see RULE2
    wr_go && avs_address == irc_pkg::GLOBAL_CFG_ADDR && avs_byteenable[1]
    && avs_writedata[irc_pkg::MODE_BIT] |=> bucket0_rate_mode_select)
    else $error("normalized mode not selected");

  // Mode bit holds without a write
  mode_hold_a: assert property (@(posedge clk) disable iff (!reset_n) // see RULE3
    !init_reg && !wr_go |=> $stable(bucket0_rate_mode_select))
    else $error("mode changed without write");

  // Mask takes the written value
  mask_write_a: assert property (@(posedge clk) disable iff (!reset_n) // see RULE4
    wr_go && avs_address == irc_pkg::GLOBAL_CFG_ADDR && avs_byteenable[0]
    |=> bucket0_traffic_class_mask == $past(avs_writedata[irc_pkg::MASK_MSB:0]))
    else $error("mask write lost");

  // Mask holds without a lane 0 write
  mask_hold_a: assert property (@(posedge clk) disable iff (!reset_n) // see RULE4
    !init_reg && !(wr_go && avs_address == irc_pkg::GLOBAL_CFG_ADDR && avs_byteenable[0])
    |=> $stable(bucket0_traffic_class_mask))
    else $error("mask changed without write");

  // Port enables hold without a write
  en_hold_a: assert property (@(posedge clk) disable iff (!reset_n) // see RULE7
    !init_reg && !(wr_go && avs_address == irc_pkg::PORT_EN_ADDR && avs_byteenable[0])
    |=> $stable(port_en_reg))
    else $error("enables changed without write");

  // Port 0 is never policed while its enable is clear
  police_gate_a: assert property (@(posedge clk) disable iff (!reset_n) // see RULE7
    !port_en_reg[0] |=> !bucket0_police[0])
    else $error("policing while disabled");

  // Broadcast class is policed when selected
  police_class_a: assert property (@(posedge clk) disable iff (!reset_n) // see RULE5
    port_en_reg[0] && frame_class_in[0][3] && bucket0_traffic_class_mask[3]
    |=> bucket0_police[0])
    else $error("broadcast not policed");

  // A class outside the mask is never policed, per port
  generate
    for (genvar c = 0; c < PORTS; c++) begin : g_chk
      police_mask_a: assert property (@(posedge clk) disable iff (!reset_n) // see RULE5
        !(|(frame_class_in[c] & bucket0_traffic_class_mask)) |=> !bucket0_police[c])
        else $error("unselected class policed");
    end
  endgenerate

  // Config read returns mode, reserved bit and mask
  cfg_read_a: assert property (@(posedge clk) disable iff (!reset_n) // see RULE3
    rd_go && avs_address == irc_pkg::GLOBAL_CFG_ADDR
    |=> avs_readdata == {23'h000000, $past(bucket0_rate_mode_select), $past(rsvd7_reg),
                         $past(bucket0_traffic_class_mask)})
    else $error("config read wrong");

  // Status read returns the policing outputs
  status_read_a: assert property (@(posedge clk) disable iff (!reset_n) // see RULE5
    rd_go && avs_address == irc_pkg::STATUS_ADDR
    |=> avs_readdata == 32'($past(bucket0_police)))
    else $error("status read wrong");

  // Unmapped reads return zero
  unmapped_read_a: assert property (@(posedge clk) disable iff (!reset_n)
    rd_go && avs_address != irc_pkg::GLOBAL_CFG_ADDR && avs_address != irc_pkg::PORT_EN_ADDR
    && avs_address != irc_pkg::STATUS_ADDR |=> avs_readdata == irc_pkg::UNMAPPED_READ)
    else $error("unmapped read not zero");

  // No answer while the strap is being loaded
  wait_init_a: assert property (@(posedge clk) disable iff (!reset_n)
    init_reg |-> avs_waitrequest)
    else $error("answered during strap load");

  // Waitrequest drops for a single cycle
  wait_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");

  // Acknowledge and waitrequest stay complementary
  ack_match_a: assert property (@(posedge clk) disable iff (!reset_n)
    avs_waitrequest != ack_reg)
    else $error("ack and waitrequest disagree");

  // Every request is answered within two cycles
  bus_answer_a: assert property (@(posedge clk) disable iff (!reset_n)
    (avs_read || avs_write) && !init_reg && avs_waitrequest |-> ##[0:2] !avs_waitrequest)
    else $error("bus never answered");

  // Main scenarios
  rd_cfg_c: cover property (@(posedge clk) rd_go && avs_address == irc_pkg::GLOBAL_CFG_ADDR);
  wr_mode_c: cover property (@(posedge clk) wr_go && avs_writedata[irc_pkg::MODE_BIT]);
  police_c: cover property (@(posedge clk) |bucket0_police);
  strap_low_c: cover property (@(posedge clk) reset_n && init_reg && !strap_sync_reg);
  wr_stall_c: cover property (@(posedge clk) avs_write && avs_waitrequest && !init_reg);
endmodule

// [design/irc_pkg.sv]
// Constants for the ingress bucket 0 rate configuration register block.
// Assumes an Avalon-MM slave with 32-bit data and word-aligned byte addresses.
// Behaviour
// RULE1 - With rate mode bit 8 at 0 the per-port rate count is an absolute rate.
// RULE2 - With rate mode bit 8 at 1 the rate count is normalized to the port link speed.
// RULE3 - The rate mode bit is read/write and resets to the storm limit strap value.
// RULE4 - Bits 6:0 hold a seven-bit traffic class mask; a set bit polices that class.
// RULE5 - Mask bits 0 to 6 are uc hit, mc hit, reserved MAC, broadcast, mc miss, uc miss, reserved.
// RULE6 - At reset the mask loads 0001000 with the strap high and 0000000 with it low.
// RULE7 - A port is policed only while its bucket 0 enable is set; the enable resets to the strap.
// RULE8 - Software keeps reserved bit 7 at one and writes zero to reserved mask bit 6.
package irc_pkg;
  localparam logic [7:0]  GLOBAL_CFG_ADDR  = 8'h00;
  localparam logic [7:0]  PORT_EN_ADDR     = 8'h04;
  localparam logic [7:0]  STATUS_ADDR      = 8'h08;
  localparam int          MODE_BIT         = 8;
  localparam int          RSVD_BIT         = 7;
  localparam int          MASK_MSB         = 6;
  localparam logic        RSVD_RESET       = 1'b1;
  localparam logic [6:0]  MASK_STRAP_HIGH  = 7'h08;
  localparam logic [6:0]  MASK_STRAP_LOW   = 7'h00;
  localparam logic [31:0] UNMAPPED_READ    = 32'h0000_0000;
endpackage

// [bench/test_ingress_bucket0_rate_config.sv]
// Bench for irc_top: register access, strap reset defaults and policing.
// Assumes a 100 MHz clock and Avalon-MM access with one wait cycle.
`timescale 1ns/10ps
module test_ingress_bucket0_rate_config;
  logic        clk = 0, reset_n = 0, rd = 0, wr = 0, strap = 1, mode;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, q;
  logic [6:0]  cls [7];
  logic [6:0]  pol, mask;
  logic        waitreq;
  int          bad_count = 0, comparisons = 0, cycles = 0;
  irc_top #(.PORTS(7)) u_dut (.clk(clk), .reset_n(reset_n), .avs_address(addr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(4'hF),
    .avs_readdata(rdata), .avs_waitrequest(waitreq), .storm_limit_strap(strap),
    .frame_class_in(cls), .bucket0_police(pol), .bucket0_rate_mode_select(mode),
    .bucket0_traffic_class_mask(mask));
  // Clock and hang guard
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One Avalon-MM word access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= w; rd <= !w; addr <= a; wdata <= d;
    do @(posedge clk); while (waitreq !== 1'b0);
    q = rdata;
    rd <= 1'b0; wr <= 1'b0;
  endtask
  task automatic t_defaults(input logic s, input logic [31:0] cfg, input logic [31:0] en);
    @(posedge clk);
    reset_n <= 1'b0; strap <= s;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    bus(0, 8'h00, 32'h0); chk(q, cfg);
    chk(32'({mode, mask}), 32'({cfg[8], cfg[6:0]}));
    bus(0, 8'h04, 32'h0); chk(q, en);
    bus(0, 8'h40, 32'h0); chk(q, 32'h0);
    $display("defaults test done");
  endtask
  task automatic t_mode;
    bus(1, 8'h00, 32'h0A5);
    bus(0, 8'h00, 32'h0); chk(q, 32'h0A5);
    chk(32'(mode), 32'h0);
    bus(1, 8'h00, 32'h1B3);
    @(negedge clk);
    chk(32'({mode, mask}), 32'h0B3);
    $display("mode test done");
  endtask
  task automatic t_police;
    bus(1, 8'h00, 32'h088);
    @(posedge clk); #1;
    chk(32'(pol), 32'h08);
    bus(1, 8'h00, 32'h0BF);
    bus(1, 8'h04, 32'h055);
    @(posedge clk); #1;
    chk(32'(pol), 32'h15);
    bus(0, 8'h08, 32'h0); chk(q, 32'h15);
    $display("police test done");
  endtask
  task automatic final_report;
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Main sequence: one distinct class bit per port
  initial begin
    for (int i = 0; i < 7; i++) cls[i] = 7'h01 << i;
    t_defaults(1'b1, 32'h188, 32'h07F);
    t_mode();
    t_police();
    t_defaults(1'b0, 32'h080, 32'h000);
    final_report();
  end
endmodule
